// File: verilog/nvm_pkg.sv
// shared constants for the byte eeprom access controller
// assumes a 32-bit ahb-lite register bus and an 8-bit, 256-entry store
package nvm_pkg;

  // store geometry
  localparam int NVM_DEPTH = 256;
  localparam int BYTE_W = 8;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;

  // register byte offsets, decoded on haddr[7:0]
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // control register fields
  localparam int CTRL_RD_BIT = 0;
  localparam int CTRL_PROG_BIT = 1;
  localparam int CTRL_ARM_BIT = 2;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_MODE_MSB = 5;

  // program mode encodings
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // interrupt status and mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_RD_BIT = 1;
  localparam int IRQ_REF_BIT = 2;

  // reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // timing counts in cpu clock cycles
  localparam logic [2:0] ARM_WINDOW = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] PROG_STALL = 3'h2;

  // programming phase lengths in calibrated oscillator ticks
  localparam logic [7:0] ERASE_TICKS = 8'h10;
  localparam logic [7:0] WRITE_TICKS = 8'h10;

endpackage

// File: verilog/nvm_byte_store.sv
// 256 x 8 nonvolatile byte array with one write and one read port
// assumes the caller only pulses wr_en_i once per finished phase
`timescale 1ns/1ps
`default_nettype none
module nvm_byte_store
  import nvm_pkg::*;
(
  input wire logic mclk_i, // cpu clock
  input wire logic wr_en_i, // end-of-phase pulse
  input wire logic erase_i, // 1 erase, 0 program
  input wire logic [7:0] addr_i, // byte address
  input wire logic [7:0] wdata_i, // byte to program
  output logic [7:0] rdata_o // byte at addr_i
);

  // cell array, no reset: contents survive any reset
  logic [BYTE_W-1:0] mem [0:NVM_DEPTH-1];

  // erase drives cells to all ones; program can only clear bits,
  // so programming an unerased byte leaves a mix of old and new
  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      if (erase_i) begin
        mem[addr_i] <= BYTE_ERASED;
      end else begin
        mem[addr_i] <= mem[addr_i] & wdata_i;
      end
    end
  end

  // asynchronous read, the caller registers it
  assign rdata_o = mem[addr_i];

endmodule
`default_nettype wire

// File: verilog/nvm_prog_engine.sv
// programming sequencer timed by the calibrated oscillator
// assumes osc_i is asynchronous to mclk_i and far slower than it
`timescale 1ns/1ps
`default_nettype none
module nvm_prog_engine
  import nvm_pkg::*;
(
  input wire logic mclk_i, // cpu clock
  input wire logic por_i, // supply-level reset, async high
  input wire logic osc_i, // calibrated oscillator pin
  input wire logic start_i, // one-cycle start request
  input wire logic [1:0] mode_i, // program mode at start
  output logic busy_o, // operation in progress
  output logic done_o, // one-cycle completion pulse
  output logic wr_en_o, // one-cycle cell update pulse
  output logic erase_o // cell update is an erase
);

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} eng_state_e;

  eng_state_e state_ff; // sequencer state
  logic [1:0] mode_ff; // latched program mode
  logic [7:0] tick_cnt_ff; // ticks left in phase
  logic osc_s1_ff, osc_s2_ff, osc_s3_ff; // sync chain + edge history
  logic osc_tick; // rising oscillator edge
  logic phase_end; // last tick of a phase

  // oscillator sync; the second and third stages feed the edge detector
  always_ff @(posedge mclk_i or posedge por_i) begin
    if (por_i) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      osc_s1_ff <= osc_i;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  assign osc_tick = osc_s2_ff & ~osc_s3_ff;
  assign phase_end = osc_tick & (tick_cnt_ff == 8'h01);
  assign busy_o = (state_ff != ST_IDLE);

  // sequencer; only por_i resets it so a cpu reset cannot cut a write
  always_ff @(posedge mclk_i or posedge por_i) begin
    if (por_i) begin
      state_ff <= ST_IDLE;
      mode_ff <= MODE_RST;
      tick_cnt_ff <= 8'h00;
      done_o <= 1'b0;
      wr_en_o <= 1'b0;
      erase_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      wr_en_o <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (start_i) begin
            mode_ff <= mode_i;
            if (mode_i == MODE_WRITE) begin
              state_ff <= ST_WRITE;
              tick_cnt_ff <= WRITE_TICKS;
            end else begin
              state_ff <= ST_ERASE;
              tick_cnt_ff <= ERASE_TICKS;
            end
          end
        end
        ST_ERASE: begin
          if (osc_tick) begin
            tick_cnt_ff <= tick_cnt_ff - 8'h01;
          end
          if (phase_end) begin
            wr_en_o <= 1'b1;
            erase_o <= 1'b1;
            if (mode_ff == MODE_ATOMIC) begin
              state_ff <= ST_WRITE;
              tick_cnt_ff <= WRITE_TICKS;
            end else begin
              state_ff <= ST_IDLE;
              done_o <= 1'b1;
            end
          end
        end
        ST_WRITE: begin
          if (osc_tick) begin
            tick_cnt_ff <= tick_cnt_ff - 8'h01;
          end
          if (phase_end) begin
            wr_en_o <= 1'b1;
            erase_o <= 1'b0;
            state_ff <= ST_IDLE;
            done_o <= 1'b1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: verilog/byte_eeprom_access_controller.sv
// top of the byte eeprom access controller: ahb-lite register slave,
// arm window, cpu stall generation, interrupt status and the store.
// assumes a single ahb-lite slave whose hreadyout is the bus hready,
// and a calibrated oscillator on osc_i that is asynchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module byte_eeprom_access_controller
  import nvm_pkg::*;
(
  input wire logic mclk_i, // cpu clock, 100 MHz
  input wire logic reset_i, // cpu reset, async high
  input wire logic por_i, // supply reset, async high
  input wire logic osc_i, // calibrated oscillator pin
  input wire logic hsel_i, // ahb slave select
  input wire logic [31:0] haddr_i, // ahb address
  input wire logic [1:0] htrans_i, // ahb transfer type
  input wire logic hwrite_i, // ahb write flag
  input wire logic [2:0] hsize_i, // ahb size, word only
  input wire logic [31:0] hwdata_i, // ahb write data
  input wire logic hready_i, // ahb bus ready
  output logic hreadyout_o, // slave ready
  output logic hresp_o, // slave response, always okay
  output logic [31:0] hrdata_o, // read data
  output logic irq_o // level interrupt
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] addr_ff; // nvm_addr_low_reg
  logic [7:0] data_ff; // nvm_data_reg
  logic [1:0] mode_ff; // program_mode_bits
  logic [2:0] arm_cnt_ff; // program_arm window left
  logic [2:0] stall_cnt_ff; // extra wait states left
  logic wr_pend_ff; // write data phase pending
  logic rd_pend_ff; // read data phase pending
  logic [7:0] areg_ff; // captured byte offset
  logic [IRQ_W-1:0] irq_stat_ff; // sticky event flags
  logic [IRQ_W-1:0] irq_mask_ff; // interrupt enables
  logic [31:0] rdata_ff; // registered read data
  logic [7:0] tgt_addr_ff; // byte address of the running operation
  logic [7:0] tgt_data_ff; // byte value of the running operation

  // next values
  logic [7:0] nxt_addr;
  logic [7:0] nxt_data;
  logic [1:0] nxt_mode;
  logic [2:0] nxt_arm_cnt;
  logic [2:0] nxt_stall_cnt;
  logic [IRQ_W-1:0] nxt_irq_stat;
  logic [IRQ_W-1:0] nxt_irq_mask;

  // ---------------------------------------------------------------
  // bus decode wires
  // ---------------------------------------------------------------
  logic addr_phase; // address phase taken this edge
  logic sel_addr, sel_data, sel_ctrl, sel_stat, sel_mask; // offset hits
  logic ctrl_wr; // control register write
  logic rd_req, pg_req, arm_req; // strobe bits written
  logic [1:0] wmode; // mode field of the write
  logic armed; // arm window open
  logic busy; // programming in progress
  logic start_ok; // accepted program start
  logic rd_ok; // accepted read
  logic refuse_evt; // refused start or read
  logic stall_now; // stall begins this cycle
  logic [IRQ_W-1:0] w1c; // status bits being cleared
  logic [IRQ_W-1:0] irq_evt; // status bits being set
  logic [31:0] rd_mux; // read data selection
  logic [31:0] ctrl_view; // control register as read
  logic [7:0] store_rdata; // byte at store_addr
  logic [7:0] store_addr; // store port address
  logic eng_done; // programming finished
  logic eng_wr_en; // cell update pulse
  logic eng_erase; // cell update is an erase

  // address phase only when selected, non-idle and the bus is ready
  assign addr_phase = hsel_i & htrans_i[1] & hready_i;

  // register decode on the captured byte offset
  assign sel_addr = (areg_ff == OFS_ADDR);
  assign sel_data = (areg_ff == OFS_DATA);
  assign sel_ctrl = (areg_ff == OFS_CTRL);
  assign sel_stat = (areg_ff == OFS_IRQ_STAT);
  assign sel_mask = (areg_ff == OFS_IRQ_MASK);

  // control write fields, sampled in the first data-phase cycle
  assign ctrl_wr = wr_pend_ff & sel_ctrl;
  assign rd_req = ctrl_wr & hwdata_i[CTRL_RD_BIT];
  assign pg_req = ctrl_wr & hwdata_i[CTRL_PROG_BIT];
  assign arm_req = ctrl_wr & hwdata_i[CTRL_ARM_BIT];
  assign wmode = hwdata_i[CTRL_MODE_MSB:CTRL_MODE_LSB];
  assign armed = (arm_cnt_ff != 3'h0);

  // a start needs an open window, a legal mode and an idle engine;
  // arm and strobe in one write do not count as a prior arm
  assign start_ok = pg_req & ~busy & armed & ~arm_req
                    & (wmode != MODE_RSVD);

  // engine updates use the latched target, reads the software address
  assign store_addr = (busy | eng_wr_en) ? tgt_addr_ff : addr_ff;

  // program strobe wins over a read strobe in the same write
  assign rd_ok = rd_req & ~busy & ~pg_req;

  // a read or program strobe that was not honoured is reported
  assign refuse_evt = (pg_req & ~start_ok) | (rd_req & ~rd_ok);

  // the write data phase itself is the first stalled cycle
  assign stall_now = rd_ok | start_ok;

  // read wait state, strobe stall and its tail all hold the bus
  assign hreadyout_o = ~(rd_pend_ff | stall_now | (stall_cnt_ff != 3'h0));
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_ff;

  // events and write-one-to-clear mask for the status register
  assign irq_evt[IRQ_DONE_BIT] = eng_done;
  assign irq_evt[IRQ_RD_BIT] = rd_ok;
  assign irq_evt[IRQ_REF_BIT] = refuse_evt;
  assign w1c = (wr_pend_ff & sel_stat) ? hwdata_i[IRQ_W-1:0] : IRQ_RST;

  // level interrupt from unmasked sticky flags
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // control readback: strobe shows busy, arm shows the open window
  assign ctrl_view = {26'h0000000, mode_ff, 1'b0, armed, busy, 1'b0};

  // read data selection; unmapped offsets read as zero
  assign rd_mux = sel_addr ? {24'h000000, addr_ff} :
                  sel_data ? {24'h000000, data_ff} :
                  sel_ctrl ? ctrl_view :
                  sel_stat ? {29'h00000000, irq_stat_ff} :
                  sel_mask ? {29'h00000000, irq_mask_ff} : 32'h00000000;

  // ---------------------------------------------------------------
  // next-value logic
  // ---------------------------------------------------------------

  // address: frozen while busy so the engine's target stays put
  always_comb begin
    nxt_addr = addr_ff;
    if (wr_pend_ff & sel_addr & ~busy) begin
      nxt_addr = hwdata_i[7:0];
    end
  end

  // data: software byte or the byte fetched by a read strobe
  always_comb begin
    nxt_data = data_ff;
    if (rd_ok) begin
      nxt_data = store_rdata;
    end else if (wr_pend_ff & sel_data & ~busy) begin
      nxt_data = hwdata_i[7:0];
    end
  end

  // mode: only changes while the engine is idle
  always_comb begin
    nxt_mode = mode_ff;
    if (ctrl_wr & ~busy) begin
      nxt_mode = wmode;
    end
  end

  // arm window: opens for four cycles, consumed by a start
  always_comb begin
    nxt_arm_cnt = arm_cnt_ff;
    if (start_ok) begin
      nxt_arm_cnt = 3'h0;
    end else if (arm_req & ~pg_req & ~busy) begin
      nxt_arm_cnt = ARM_WINDOW;
    end else if (armed) begin
      nxt_arm_cnt = arm_cnt_ff - 3'h1;
    end
  end

  // stall tail: the first stalled cycle is stall_now itself
  always_comb begin
    nxt_stall_cnt = stall_cnt_ff;
    if (rd_ok) begin
      nxt_stall_cnt = READ_STALL - 3'h1;
    end else if (start_ok) begin
      nxt_stall_cnt = PROG_STALL - 3'h1;
    end else if (stall_cnt_ff != 3'h0) begin
      nxt_stall_cnt = stall_cnt_ff - 3'h1;
    end
  end

  // sticky flags: a new event beats a clear in the same cycle
  always_comb begin
    nxt_irq_stat = (irq_stat_ff & ~w1c) | irq_evt;
  end

  // mask register, plain read/write
  always_comb begin
    nxt_irq_mask = irq_mask_ff;
    if (wr_pend_ff & sel_mask) begin
      nxt_irq_mask = hwdata_i[IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // flops
  // ---------------------------------------------------------------

  // bus phase tracking; no capture while the bus is stalled
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      areg_ff <= 8'h00;
    end else if (addr_phase) begin
      wr_pend_ff <= hwrite_i;
      rd_pend_ff <= ~hwrite_i;
      areg_ff <= haddr_i[7:0];
    end else begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
    end
  end

  // read data sampled in the wait state so a prior write is visible
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_pend_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  // software-visible registers
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_ff <= ADDR_RST;
      data_ff <= DATA_RST;
      mode_ff <= MODE_RST;
    end else begin
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      mode_ff <= nxt_mode;
    end
  end

  // operation target; only por_i clears it, because a cpu reset wipes
  // the software copies while the engine still has a cell to update
  always_ff @(posedge mclk_i or posedge por_i) begin
    if (por_i) begin
      tgt_addr_ff <= ADDR_RST;
      tgt_data_ff <= DATA_RST;
    end else if (start_ok) begin
      tgt_addr_ff <= addr_ff;
      tgt_data_ff <= data_ff;
    end
  end

  // timing counters
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      arm_cnt_ff <= 3'h0;
      stall_cnt_ff <= 3'h0;
    end else begin
      arm_cnt_ff <= nxt_arm_cnt;
      stall_cnt_ff <= nxt_stall_cnt;
    end
  end

  // interrupt registers
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_stat_ff <= IRQ_RST;
      irq_mask_ff <= IRQ_RST;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------

  // engine survives reset_i; only por_i stops a running operation
  nvm_prog_engine u_engine (
    .mclk_i(mclk_i),
    .por_i(por_i),
    .osc_i(osc_i),
    .start_i(start_ok),
    .mode_i(wmode),
    .busy_o(busy),
    .done_o(eng_done),
    .wr_en_o(eng_wr_en),
    .erase_o(eng_erase)
  );

  // the byte array; a running operation writes its latched target
  nvm_byte_store u_store (
    .mclk_i(mclk_i),
    .wr_en_i(eng_wr_en),
    .erase_i(eng_erase),
    .addr_i(store_addr),
    .wdata_i(tgt_data_ff),
    .rdata_o(store_rdata)
  );

endmodule
`default_nettype wire

// File: test/nvm_access_checker.sv
// port-level assertions for the byte eeprom access controller
// assumes the bus hready is the slave's own hreadyout
`timescale 1ns/1ps
`default_nettype none
module nvm_access_checker
  import nvm_pkg::*;
(
  input wire logic mclk_i, // cpu clock
  input wire logic reset_i, // cpu reset
  input wire logic por_i, // supply reset
  input wire logic osc_i, // oscillator
  input wire logic hsel_i, // select
  input wire logic [31:0] haddr_i, // address
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // write flag
  input wire logic [2:0] hsize_i, // size
  input wire logic [31:0] hwdata_i, // write data
  input wire logic hready_i, // bus ready
  input wire logic hreadyout_o, // slave ready
  input wire logic hresp_o, // response
  input wire logic [31:0] hrdata_o, // read data
  input wire logic irq_o // interrupt
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic wdp_ff; // first write data cycle
  logic [7:0] waddr_ff; // offset of that write
  logic [2:0] arm_age_ff; // cycles since arm, saturates at 5
  wire taken = hsel_i && htrans_i[1] && hready_i; // address phase accepted
  wire rd_tk = taken && !hwrite_i; // read accepted
  wire ctrl_wdp = wdp_ff && waddr_ff == OFS_CTRL; // control write data
  wire strobe_wr = ctrl_wdp && hwdata_i[CTRL_PROG_BIT]; // program strobe written
  wire armed = arm_age_ff != 3'h0 && arm_age_ff <= ARM_WINDOW; // window open
  wire arm_wr = ctrl_wdp && hwdata_i[CTRL_ARM_BIT] && !hwdata_i[CTRL_PROG_BIT];
  // age only grows so a stale arm never looks fresh again
  wire [2:0] nxt_arm_age = arm_wr ? 3'h1 :
    (arm_age_ff != 3'h0 && arm_age_ff < 3'h5) ? arm_age_ff + 3'h1 : arm_age_ff;
  // data phase tracking
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wdp_ff <= 1'b0;
      waddr_ff <= 8'h00;
      arm_age_ff <= 3'h0;
    end else begin
      wdp_ff <= taken && hwrite_i;
      waddr_ff <= haddr_i[7:0];
      arm_age_ff <= nxt_arm_age;
    end
  end
  sequence rd_wait_s;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  sequence low4_s;
    !hreadyout_o [*4] ##1 hreadyout_o;
  endsequence
  sequence low2_s;
    !hreadyout_o [*2] ##1 hreadyout_o;
  endsequence
  resp_okay_a: assert property (hresp_o == 1'b0) else $error("response not okay");
  rd_wait_a: assert property (rd_tk |=> rd_wait_s) else $error("read wait wrong");
  ctrl_rd_a: assert property (rd_tk && haddr_i[7:0] == OFS_CTRL |=> ##1
    (hrdata_o[31:6] == 26'h0 && hrdata_o[3] == 1'b0 && hrdata_o[0] == 1'b0))
    else $error("control read reserved bits set");
  unmapped_rd_a: assert property (rd_tk && haddr_i[7:0] > OFS_IRQ_MASK |=> ##1
    hrdata_o == 32'h0) else $error("unmapped read not zero");
  rd_stall_a: assert property (ctrl_wdp && hwdata_i[CTRL_RD_BIT] &&
    !hwdata_i[CTRL_PROG_BIT] && !hreadyout_o |-> low4_s) else $error("read stall wrong");
  prog_stall_a: assert property (strobe_wr && !hreadyout_o |-> low2_s)
    else $error("program stall wrong");
  plain_wr_a: assert property (wdp_ff && !(ctrl_wdp && (hwdata_i[CTRL_RD_BIT] ||
    hwdata_i[CTRL_PROG_BIT])) |-> hreadyout_o) else $error("plain write stalled");
  no_arm_a: assert property (strobe_wr && (!armed || hwdata_i[CTRL_ARM_BIT])
    |-> hreadyout_o) else $error("unarmed strobe started");
  rsvd_mode_a: assert property (strobe_wr &&
    hwdata_i[CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_RSVD |-> hreadyout_o)
    else $error("reserved mode started");
endmodule
bind byte_eeprom_access_controller nvm_access_checker chk_u (.mclk_i(mclk_i),
  .reset_i(reset_i), .por_i(por_i), .osc_i(osc_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .hrdata_o(hrdata_o), .irq_o(irq_o));
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the byte eeprom access controller
// assumes this bench is the only ahb-lite master and drives the oscillator
`timescale 1ns/1ps
`default_nettype none
module tb
  import nvm_pkg::*;
;
  logic mclk_i = 1'b0; // cpu clock
  logic reset_i = 1'b1; // cpu reset
  logic por_i = 1'b1; // supply reset
  logic osc_i = 1'b0; // oscillator
  logic osc_run = 1'b1; // stop to freeze programming
  logic [31:0] haddr_i = 32'h0; // bus address
  logic [1:0] htrans_i = 2'h0; // bus transfer type
  logic hwrite_i = 1'b0; // bus write flag
  logic [31:0] hwdata_i = 32'h0; // bus write data
  wire hreadyout_o; // slave ready, fed back as hready
  wire hresp_o; // response
  wire [31:0] hrdata_o; // read data
  wire irq_o; // interrupt
  int error_cnt = 0; // mismatches
  int n_compared = 0; // comparisons
  int wait_n = 0; // edges spent in the last wait for hready
  always #5 mclk_i = ~mclk_i;
  // odd half period keeps the oscillator unrelated to the cpu clock
  always #21 if (osc_run) osc_i = ~osc_i;
  byte_eeprom_access_controller dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .por_i(por_i),
    .osc_i(osc_i), .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .irq_o(irq_o));
  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 40);
    wait_n = n;
    if (n >= 40) begin
      error_cnt++;
      close_out();
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_rdy();
    rd = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    xfer(1'b1, a, d, v);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask
  // poll busy; bound covers 32 ticks of the oscillator
  task automatic wait_idle();
    logic [31:0] v;
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_CTRL, 32'h0, v);
      n++;
    end while (v[CTRL_PROG_BIT] !== 1'b0 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      close_out();
    end
  endtask
  // gap of 2 idle cycles puts the strobe at the last armed cycle
  task automatic start_prog(input logic [7:0] a, input logic [7:0] d, input logic [1:0] m,
      input int gap);
    wr(OFS_ADDR, {24'h0, a});
    wr(OFS_DATA, {24'h0, d});
    wr(OFS_CTRL, {26'h0, m, 4'h4});
    repeat (gap) @(posedge mclk_i);
    wr(OFS_CTRL, {26'h0, m, 4'h2});
  endtask
  task automatic rd_byte(input logic [7:0] a, input logic [7:0] exp);
    wr(OFS_ADDR, {24'h0, a});
    wr(OFS_CTRL, 32'h1);
    chk(wait_n, 32'h5);
    rd_chk(OFS_DATA, {24'h0, exp});
  endtask
  task automatic refused();
    logic [31:0] v;
    xfer(1'b0, OFS_CTRL, 32'h0, v);
    chk(v & 32'h2, 32'h0);
    rd_chk(OFS_IRQ_STAT, 32'h4);
    wr(OFS_IRQ_STAT, 32'h4);
  endtask
  task automatic t_reset();
    wr(8'h14, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 32'h0);
    wr(OFS_IRQ_MASK, 32'h7);
    chk(wait_n, 32'h1);
    rd_chk(OFS_IRQ_MASK, 32'h7);
    wr(OFS_IRQ_MASK, 32'h0);
  endtask
  task automatic t_atomic();
    osc_run = 1'b0; // frozen oscillator must hold the operation
    start_prog(8'h05, 8'h3C, MODE_ATOMIC, 2);
    chk(wait_n, 32'h3);
    repeat (100) @(posedge mclk_i);
    rd_chk(OFS_CTRL, 32'h2);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_DATA, 32'h55);
    rd_chk(OFS_IRQ_STAT, 32'h4);
    osc_run = 1'b1;
    wait_idle();
    rd_chk(OFS_DATA, 32'h3C);
    rd_byte(8'h05, 8'h3C);
    rd_chk(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h1);
    #1 chk({31'h0, irq_o}, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    #1 chk({31'h0, irq_o}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_IRQ_STAT, 32'h7);
    #1 chk({31'h0, irq_o}, 32'h0);
    rd_chk(OFS_IRQ_STAT, 32'h0);
  endtask
  task automatic t_split();
    start_prog(8'h05, 8'h00, MODE_ERASE, 2);
    wait_idle();
    rd_byte(8'h05, BYTE_ERASED);
    start_prog(8'h05, 8'hA5, MODE_WRITE, 2);
    wait_idle();
    rd_byte(8'h05, 8'hA5);
    wr(OFS_IRQ_STAT, 32'h7);
  endtask
  task automatic t_refuse();
    wr(OFS_CTRL, 32'h2);
    refused();
    start_prog(8'h05, 8'h11, MODE_ATOMIC, 3);
    refused();
    wr(OFS_CTRL, 32'h6);
    refused();
    start_prog(8'h05, 8'h11, MODE_RSVD, 2);
    refused();
    rd_byte(8'h05, 8'hA5);
  endtask
  task automatic t_survive();
    start_prog(8'h09, 8'h5A, MODE_ATOMIC, 2);
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rd_chk(OFS_CTRL, 32'h2);
    wait_idle();
    rd_byte(8'h09, 8'h5A);
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge mclk_i);
    t_reset();
    t_atomic();
    t_split();
    t_refuse();
    t_survive();
    close_out();
  end
endmodule
`default_nettype wire
